// ==== ppm_pad_mux.sv ====
// Parallel-port pin mux and pad control with its register file
`timescale 1ns/1ns
// What this block does
// - Each internal pull resistor has its own inhibit bit; test-reset pull-down is uncontrolled.
// - Slew register picks fast or slow for clock-output and memory-interface pads.
// - Only external_bus_selection decides which peripheral owns a shared pad.
// - Three-bit mode field, codes 0..6, resets to 0 where all pads are LCD.
// - Modes 1 and 6 put SPI clock and four selects on LCD control pads.
// - Modes 1 and 6 put SPI receive on data 0, transmit on data 1.
// - Modes 1 and 6 turn LCD data 2..7 into general lines 12..17.
// - Data 8..11: audio two in 1,4,6; lines 18-20,27 in 2; SPI in 3,5.
// - Data 12..15: UART in 1,4,5; lines 28..31 in 2; audio three in 3,6.
// - Third inhibit register covers only data pads 2..15.
module ppm_pad_mux
  import ppm_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [PPM_AW-1:0] addr,
  input  wire logic [PPM_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [PPM_DW-1:0] rdata,
  output logic      [15:0]       pull_inhibit_first,
  output logic      [15:0]       pull_inhibit_second,
  output logic      [15:0]       pull_inhibit_third,
  output logic                   test_reset_pull_down,
  output logic                   clock_output_pad_slow,
  output logic                   external_memory_interface_slow,
  output logic      [2:0]        parallel_port_mode,
  input  wire logic [4:0]        lcd_control_out,
  input  wire logic [15:0]       lcd_data_bus_out,
  input  wire logic [15:0]       lcd_data_bus_oe,
  output logic      [15:0]       lcd_data_bus_in,
  input  wire logic              spi_clock,
  input  wire logic [3:0]        spi_select,
  input  wire logic              spi_transmit,
  output logic                   spi_receive,
  input  wire logic [13:0]       general_purpose_line_out,
  input  wire logic [13:0]       general_purpose_line_oe,
  output logic      [13:0]       general_purpose_line_in,
  input  wire logic              second_audio_clock_out,
  input  wire logic              second_audio_clock_oe,
  output logic                   second_audio_clock_in,
  input  wire logic              second_audio_frame_sync_out,
  input  wire logic              second_audio_frame_sync_oe,
  output logic                   second_audio_frame_sync_in,
  output logic                   second_audio_receive,
  input  wire logic              second_audio_transmit,
  input  wire logic              third_audio_clock_out,
  input  wire logic              third_audio_clock_oe,
  output logic                   third_audio_clock_in,
  input  wire logic              third_audio_frame_sync_out,
  input  wire logic              third_audio_frame_sync_oe,
  output logic                   third_audio_frame_sync_in,
  output logic                   third_audio_receive,
  input  wire logic              third_audio_transmit,
  input  wire logic              uart_request_to_send,
  output logic                   uart_clear_to_send,
  output logic                   uart_receive,
  input  wire logic              uart_transmit,
  output logic      [4:0]        control_pad_out,
  output logic      [15:0]       data_pad_out,
  output logic      [15:0]       data_pad_oe,
  input  wire logic [15:0]       data_pad_in
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] output_slew_select;
  logic        sel_bus;
  logic        sel_slew;
  logic        sel_inh1;
  logic        sel_inh2;
  logic        sel_inh3;

  assign sel_bus  = (addr == PPM_OFF_EXT_BUS_SEL);
  assign sel_slew = (addr == PPM_OFF_SLEW_SEL);
  assign sel_inh1 = (addr == PPM_OFF_PULL_INH_1);
  assign sel_inh2 = (addr == PPM_OFF_PULL_INH_2);
  assign sel_inh3 = (addr == PPM_OFF_PULL_INH_3);

  // The mode field is the only owner of the shared pads
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      parallel_port_mode <= PPM_MODE_RST;
    end else if (wr && sel_bus) begin
      parallel_port_mode <= wdata[PPM_MODE_MSB:PPM_MODE_LSB];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      output_slew_select <= PPM_SLEW_RST;
    end else if (wr && sel_slew) begin
      output_slew_select <= wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pull_inhibit_first  <= PPM_INH_RST;
      pull_inhibit_second <= PPM_INH_RST;
      pull_inhibit_third  <= PPM_INH_RST;
    end else begin
      if (wr && sel_inh1) begin
        pull_inhibit_first <= wdata;
      end
      if (wr && sel_inh2) begin
        pull_inhibit_second <= wdata;
      end
      if (wr && sel_inh3) begin
        pull_inhibit_third <= wdata & PPM_INH3_MASK;
      end
    end
  end

  // Read data stand for each cycle after a cycle with rd high, zero otherwise and when unmapped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= PPM_RDATA_IDLE;
    end else if (rd) begin
      rdata <= PPM_RDATA_IDLE;
      if (sel_bus) begin
        rdata[PPM_MODE_MSB:PPM_MODE_LSB] <= parallel_port_mode;
      end
      if (sel_slew) begin
        rdata <= output_slew_select;
      end
      if (sel_inh1) begin
        rdata <= pull_inhibit_first;
      end
      if (sel_inh2) begin
        rdata <= pull_inhibit_second;
      end
      if (sel_inh3) begin
        rdata <= pull_inhibit_third;
      end
    end else begin
      rdata <= PPM_RDATA_IDLE;
    end
  end

  // Test-reset pull-down has no inhibit control
  assign test_reset_pull_down           = 1'b1;
  assign clock_output_pad_slow          = output_slew_select[PPM_SLEW_CLK_BIT];
  assign external_memory_interface_slow = output_slew_select[PPM_SLEW_EXTERNAL_MEMORY_INTERFACE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; code 7 matches none, so every pad stays LCD

  logic ctrl_spi;
  logic mid_aud;
  logic mid_gpio;
  logic mid_spi;
  logic hi_uart;
  logic hi_gpio;
  logic hi_aud;

  assign ctrl_spi = (parallel_port_mode == PPM_MODE_1) || (parallel_port_mode == PPM_MODE_6);
  assign mid_aud  = (parallel_port_mode == PPM_MODE_1) || (parallel_port_mode == PPM_MODE_4)
                 || (parallel_port_mode == PPM_MODE_6);
  assign mid_gpio = (parallel_port_mode == PPM_MODE_2);
  assign mid_spi  = (parallel_port_mode == PPM_MODE_3) || (parallel_port_mode == PPM_MODE_5);
  assign hi_uart  = (parallel_port_mode == PPM_MODE_1) || (parallel_port_mode == PPM_MODE_4)
                 || (parallel_port_mode == PPM_MODE_5);
  assign hi_gpio  = (parallel_port_mode == PPM_MODE_2);
  assign hi_aud   = (parallel_port_mode == PPM_MODE_3) || (parallel_port_mode == PPM_MODE_6);

  ////////////////////////////////////////////////////////////////////////////
  // Pad routing

  logic [15:0] alt_sel;
  logic [15:0] alt_out;
  logic [15:0] alt_oe;

  assign control_pad_out = ctrl_spi ? {spi_select, spi_clock} : lcd_control_out;

  always_comb begin
    alt_sel       = {{4{hi_uart | hi_gpio | hi_aud}}, {4{mid_aud | mid_gpio | mid_spi}}, {8{ctrl_spi}}};
    alt_out       = 16'h0000;
    alt_oe        = 16'h0000;
    alt_out[1]    = spi_transmit;
    alt_oe[1]     = 1'b1;
    alt_out[7:2]  = general_purpose_line_out[5:0];
    alt_oe[7:2]   = general_purpose_line_oe[5:0];
    if (mid_aud) begin
      alt_out[11:8] = {second_audio_transmit, 1'b0, second_audio_frame_sync_out, second_audio_clock_out};
      alt_oe[11:8]  = {1'b1, 1'b0, second_audio_frame_sync_oe, second_audio_clock_oe};
    end
    if (mid_gpio) begin
      alt_out[11:8] = general_purpose_line_out[9:6];
      alt_oe[11:8]  = general_purpose_line_oe[9:6];
    end
    if (mid_spi) begin
      alt_out[11:8] = {spi_transmit, 1'b0, spi_select[0], spi_clock};
      alt_oe[11:8]  = 4'hB;
    end
    if (hi_uart) begin
      alt_out[15:12] = {uart_transmit, 1'b0, 1'b0, uart_request_to_send};
      alt_oe[15:12]  = 4'h9;
    end
    if (hi_gpio) begin
      alt_out[15:12] = general_purpose_line_out[13:10];
      alt_oe[15:12]  = general_purpose_line_oe[13:10];
    end
    if (hi_aud) begin
      alt_out[15:12] = {third_audio_transmit, 1'b0, third_audio_frame_sync_out, third_audio_clock_out};
      alt_oe[15:12]  = {1'b1, 1'b0, third_audio_frame_sync_oe, third_audio_clock_oe};
    end
  end

  // Per data pad: alternate function or LCD; LCD sees zero while displaced
  for (genvar i = 0; i < 16; i++) begin : g_pad
    assign data_pad_out[i]    = alt_sel[i] ? alt_out[i] : lcd_data_bus_out[i];
    assign data_pad_oe[i]     = alt_sel[i] ? alt_oe[i] : lcd_data_bus_oe[i];
    assign lcd_data_bus_in[i] = alt_sel[i] ? 1'b0 : data_pad_in[i];
  end

  // Peripheral inputs rest at idle levels when their pads are elsewhere
  assign spi_receive                    = ctrl_spi ? data_pad_in[0] : (mid_spi & data_pad_in[10]);
  assign general_purpose_line_in[5:0]   = ctrl_spi ? data_pad_in[7:2] : 6'h00;
  assign general_purpose_line_in[9:6]   = mid_gpio ? data_pad_in[11:8] : 4'h0;
  assign general_purpose_line_in[13:10] = hi_gpio ? data_pad_in[15:12] : 4'h0;
  assign second_audio_clock_in          = mid_aud & data_pad_in[8];
  assign second_audio_frame_sync_in     = mid_aud & data_pad_in[9];
  assign second_audio_receive           = mid_aud & data_pad_in[10];
  assign third_audio_clock_in           = hi_aud & data_pad_in[12];
  assign third_audio_frame_sync_in      = hi_aud & data_pad_in[13];
  assign third_audio_receive            = hi_aud & data_pad_in[14];
  assign uart_clear_to_send             = hi_uart & data_pad_in[13];
  assign uart_receive                   = hi_uart ? data_pad_in[14] : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_mode_write;
    wr && sel_bus;
  endsequence

  sequence s_all_lcd;
    (control_pad_out == lcd_control_out) && (data_pad_out == lcd_data_bus_out) && (data_pad_oe == lcd_data_bus_oe);
  endsequence

  sequence s_inh1_write_read;
    (wr && sel_inh1) ##1 (rd && sel_inh1);
  endsequence

  chk_mode_write_lands: assert property (s_mode_write |=> parallel_port_mode == $past(wdata[14:12]))
    else $error("mode field did not take the written value");
  chk_lcd_default_map: assert property (
    (parallel_port_mode == PPM_MODE_0 || parallel_port_mode == PPM_MODE_7) |-> s_all_lcd)
    else $error("mode 0 or 7 routed a pad away from LCD");
  chk_ctrl_spi_route: assert property (
    (parallel_port_mode == PPM_MODE_1 || parallel_port_mode == PPM_MODE_6)
    |-> control_pad_out == {spi_select, spi_clock})
    else $error("control pads not carrying SPI");
  chk_ctrl_lcd_keep: assert property (
    (parallel_port_mode != PPM_MODE_1 && parallel_port_mode != PPM_MODE_6)
    |-> control_pad_out == lcd_control_out)
    else $error("control pads left LCD outside SPI modes");
  chk_spi_data_pads: assert property (
    (parallel_port_mode == PPM_MODE_6) |-> (data_pad_out[1] == spi_transmit) && (spi_receive == data_pad_in[0]))
    else $error("SPI data pads misrouted");
  chk_spi_mode1_pads: assert property (
    (parallel_port_mode == PPM_MODE_1) |-> data_pad_out[1] == spi_transmit && data_pad_oe[1:0] == 2'h2)
    else $error("SPI data pads misrouted in mode 1");
  chk_gpio_low_route: assert property (
    (parallel_port_mode == PPM_MODE_1) |-> data_pad_out[7:2] == general_purpose_line_out[5:0])
    else $error("data 2..7 not on general lines");
  chk_mid_spi_route: assert property (
    (parallel_port_mode == PPM_MODE_3) |-> data_pad_out[8] == spi_clock && data_pad_out[9] == spi_select[0])
    else $error("data 8..9 not on SPI in mode 3");
  chk_mid_aud_input: assert property (
    (parallel_port_mode == PPM_MODE_4) |-> second_audio_receive == data_pad_in[10] && !data_pad_oe[10])
    else $error("second audio receive not on data 10 in mode 4");
  chk_mid_gpio_route: assert property (
    (parallel_port_mode == PPM_MODE_2) |-> data_pad_out[11:8] == general_purpose_line_out[9:6])
    else $error("data 8..11 not on general lines in mode 2");
  chk_high_uart_route: assert property (
    (parallel_port_mode == PPM_MODE_5) |-> data_pad_out[15] == uart_transmit && uart_receive == data_pad_in[14])
    else $error("data 12..15 not on UART in mode 5");
  chk_high_aud_route: assert property (
    (parallel_port_mode == PPM_MODE_3)
    |-> data_pad_out[15] == third_audio_transmit && third_audio_receive == data_pad_in[14])
    else $error("data 12..15 not on third audio in mode 3");
  chk_inhibit_third_low: assert property (s_mode_write or (wr && sel_inh3) |=> pull_inhibit_third[1:0] == 2'h0)
    else $error("third inhibit register kept bits 0..1");
  chk_inhibit_third_mask: assert property (
    wr && sel_inh3 |=> pull_inhibit_third[15:2] == $past(wdata[15:2]))
    else $error("third inhibit register lost a written bit");
  chk_slew_follows: assert property (wr && sel_slew |=> clock_output_pad_slow == $past(wdata[0]))
    else $error("clock pad slew not updated");
  chk_external_memory_interface_slew_follows: assert property (
    wr && sel_slew |=> external_memory_interface_slow == $past(wdata[PPM_SLEW_EXTERNAL_MEMORY_INTERFACE_BIT]))
    else $error("memory interface pad slew not updated");
  chk_inhibit_write: assert property (s_inh1_write_read |=> rdata == $past(wdata, 2))
    else $error("first inhibit register read back wrong");

endmodule

// ==== ppm_pkg.sv ====
// Register map, field layout and reset values of the pad mux block
package ppm_pkg;
  localparam int          PPM_AW               = 16;
  localparam int          PPM_DW               = 16;
  localparam logic [15:0] PPM_OFF_EXT_BUS_SEL  = 16'h1C00;
  localparam logic [15:0] PPM_OFF_SLEW_SEL     = 16'h1C16;
  localparam logic [15:0] PPM_OFF_PULL_INH_1   = 16'h1C17;
  localparam logic [15:0] PPM_OFF_PULL_INH_2   = 16'h1C18;
  localparam logic [15:0] PPM_OFF_PULL_INH_3   = 16'h1C19;
  // Mode field position inside external_bus_selection
  localparam int          PPM_MODE_LSB         = 12;
  localparam int          PPM_MODE_MSB         = 14;
  // Slew fields: set means slow transition
  localparam int          PPM_SLEW_CLK_BIT     = 0;
  localparam int          PPM_SLEW_EXTERNAL_MEMORY_INTERFACE_BIT    = 1;
  // Only data pads 2..15 have an inhibit bit in the third register
  localparam logic [15:0] PPM_INH3_MASK        = 16'hFFFC;
  localparam logic [2:0]  PPM_MODE_RST         = 3'h0;
  localparam logic [15:0] PPM_SLEW_RST         = 16'h0000;
  localparam logic [15:0] PPM_INH_RST          = 16'h0000;
  localparam logic [15:0] PPM_RDATA_IDLE       = 16'h0000;
  localparam logic [2:0]  PPM_MODE_0           = 3'h0;
  localparam logic [2:0]  PPM_MODE_1           = 3'h1;
  localparam logic [2:0]  PPM_MODE_2           = 3'h2;
  localparam logic [2:0]  PPM_MODE_3           = 3'h3;
  localparam logic [2:0]  PPM_MODE_4           = 3'h4;
  localparam logic [2:0]  PPM_MODE_5           = 3'h5;
  localparam logic [2:0]  PPM_MODE_6           = 3'h6;
  localparam logic [2:0]  PPM_MODE_7           = 3'h7;
endpackage

// ==== ppm_pad_model.sv ====
// Pad ring model: resolves each shared pad from the mux drive and the board level
`timescale 1ns/1ns
module ppm_pad_model (
  input  wire logic [15:0] data_pad_out,
  input  wire logic [15:0] data_pad_oe,
  input  wire logic [15:0] board_level,
  output logic      [15:0] data_pad_in
);
  // Driven pads read back their own level, released pads what the board or an external driver puts there
  assign data_pad_in = (data_pad_out & data_pad_oe) | (board_level & ~data_pad_oe);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the parallel-port pad mux and its register file
`timescale 1ns/1ns
module testbench import ppm_pkg::*;;
  logic        clock, rst, wr, rd, rd_seen, test_reset_pull_down, spi_clock, spi_transmit, spi_receive;
  logic        clock_output_pad_slow, external_memory_interface_slow, uart_request_to_send, uart_clear_to_send;
  logic        uart_receive, uart_transmit, second_audio_clock_out, second_audio_clock_oe, second_audio_clock_in;
  logic        second_audio_frame_sync_out, second_audio_frame_sync_oe, second_audio_frame_sync_in;
  logic        second_audio_receive, second_audio_transmit, third_audio_clock_out, third_audio_clock_oe;
  logic        third_audio_clock_in, third_audio_frame_sync_out, third_audio_frame_sync_oe;
  logic        third_audio_frame_sync_in, third_audio_receive, third_audio_transmit;
  logic [2:0]  parallel_port_mode;
  logic [3:0]  spi_select;
  logic [4:0]  lcd_control_out, control_pad_out;
  logic [13:0] general_purpose_line_out, general_purpose_line_oe, general_purpose_line_in;
  logic [15:0] addr, wdata, rdata, pull_inhibit_first, pull_inhibit_second, pull_inhibit_third, v;
  logic [15:0] lcd_data_bus_out, lcd_data_bus_oe, lcd_data_bus_in, data_pad_out, data_pad_oe, data_pad_in, board_level;
  logic [15:0] exp_q[$];
  logic [15:0] regs[5];
  logic [127:0] r;
  int          num_errors, n_checks, seed;

  ppm_pad_mux ppm_pad_mux_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pull_inhibit_first(pull_inhibit_first), .pull_inhibit_second(pull_inhibit_second),
    .pull_inhibit_third(pull_inhibit_third), .test_reset_pull_down(test_reset_pull_down),
    .clock_output_pad_slow(clock_output_pad_slow),
    .external_memory_interface_slow(external_memory_interface_slow),
    .parallel_port_mode(parallel_port_mode), .lcd_control_out(lcd_control_out),
    .lcd_data_bus_out(lcd_data_bus_out), .lcd_data_bus_oe(lcd_data_bus_oe), .lcd_data_bus_in(lcd_data_bus_in),
    .spi_clock(spi_clock), .spi_select(spi_select), .spi_transmit(spi_transmit), .spi_receive(spi_receive),
    .general_purpose_line_out(general_purpose_line_out), .general_purpose_line_oe(general_purpose_line_oe),
    .general_purpose_line_in(general_purpose_line_in), .second_audio_clock_out(second_audio_clock_out),
    .second_audio_clock_oe(second_audio_clock_oe), .second_audio_clock_in(second_audio_clock_in),
    .second_audio_frame_sync_out(second_audio_frame_sync_out),
    .second_audio_frame_sync_oe(second_audio_frame_sync_oe),
    .second_audio_frame_sync_in(second_audio_frame_sync_in), .second_audio_receive(second_audio_receive),
    .second_audio_transmit(second_audio_transmit), .third_audio_clock_out(third_audio_clock_out),
    .third_audio_clock_oe(third_audio_clock_oe), .third_audio_clock_in(third_audio_clock_in),
    .third_audio_frame_sync_out(third_audio_frame_sync_out),
    .third_audio_frame_sync_oe(third_audio_frame_sync_oe),
    .third_audio_frame_sync_in(third_audio_frame_sync_in), .third_audio_receive(third_audio_receive),
    .third_audio_transmit(third_audio_transmit), .uart_request_to_send(uart_request_to_send),
    .uart_clear_to_send(uart_clear_to_send), .uart_receive(uart_receive), .uart_transmit(uart_transmit),
    .control_pad_out(control_pad_out), .data_pad_out(data_pad_out), .data_pad_oe(data_pad_oe),
    .data_pad_in(data_pad_in)
  );
  ppm_pad_model ppm_pad_model_i (
    .data_pad_out(data_pad_out), .data_pad_oe(data_pad_oe), .board_level(board_level), .data_pad_in(data_pad_in)
  );

  always #25 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  task report_and_stop;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task shake;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {lcd_control_out, lcd_data_bus_out, lcd_data_bus_oe, spi_clock, spi_select, spi_transmit, general_purpose_line_out,
     general_purpose_line_oe, second_audio_clock_out, second_audio_clock_oe, second_audio_frame_sync_out,
     second_audio_frame_sync_oe, second_audio_transmit, third_audio_clock_out, third_audio_clock_oe,
     third_audio_frame_sync_out, third_audio_frame_sync_oe, third_audio_transmit, uart_request_to_send,
     uart_transmit, board_level} <= r[98:0];
  endtask

  task wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask

  task pads(input logic [2:0] m);
    logic [15:0] e, k, l, o;
    logic [13:0] g;
    logic        sp, a2, a3, ua;
    e = lcd_data_bus_out;
    o = lcd_data_bus_oe;
    g = 14'h0000;
    k = 16'hFFFF;
    l = 16'hFFFF;
    sp = (m == PPM_MODE_1 || m == PPM_MODE_6);
    a2 = (m == PPM_MODE_1 || m == PPM_MODE_4 || m == PPM_MODE_6);
    a3 = (m == PPM_MODE_3 || m == PPM_MODE_6);
    ua = (m == PPM_MODE_1 || m == PPM_MODE_4 || m == PPM_MODE_5);
    if (sp) begin
      l[7:0] = 8'h00;
      k[0] = 1'b0;
      e[7:0] = {general_purpose_line_out[5:0], spi_transmit, 1'b0};
      o[7:0] = {general_purpose_line_oe[5:0], 2'h2};
      g[5:0] = data_pad_in[7:2];
      check(16'(general_purpose_line_in[5:0]), 16'(data_pad_in[7:2]));
    end
    if (m != PPM_MODE_0 && m != PPM_MODE_7) begin
      l[15:8] = 8'h00;
      if (m != PPM_MODE_2) k[10] = 1'b0;
    end
    case (m)
      PPM_MODE_1, PPM_MODE_4, PPM_MODE_6: begin
        e[11:8] = {second_audio_transmit, 1'b0, second_audio_frame_sync_out, second_audio_clock_out};
        o[11:8] = {1'b1, 1'b0, second_audio_frame_sync_oe, second_audio_clock_oe};
      end
      PPM_MODE_3, PPM_MODE_5: begin
        e[11:8] = {spi_transmit, 1'b0, spi_select[0], spi_clock};
        o[11:8] = 4'hB;
      end
      PPM_MODE_2: begin
        e[15:8] = general_purpose_line_out[13:6];
        o[15:8] = general_purpose_line_oe[13:6];
        g[13:6] = data_pad_in[15:8];
      end
      default: ;
    endcase
    if (ua) begin
      e[15:12] = {uart_transmit, 2'b00, uart_request_to_send};
      o[15:12] = 4'h9;
      k[14:13] = 2'b00;
    end
    if (a3) begin
      e[15:12] = {third_audio_transmit, 1'b0, third_audio_frame_sync_out, third_audio_clock_out};
      o[15:12] = {1'b1, 1'b0, third_audio_frame_sync_oe, third_audio_clock_oe};
      k[14] = 1'b0;
    end
    check(data_pad_out & k, e & k);
    check(data_pad_oe & ~k, 16'h0000);
    check(data_pad_oe, o);
    check(16'(uart_clear_to_send), ua ? 16'(data_pad_in[13]) : 16'h0000);
    check(16'(general_purpose_line_in), 16'(g));
    check(16'({second_audio_receive, second_audio_frame_sync_in, second_audio_clock_in}),
          a2 ? 16'(data_pad_in[10:8]) : 16'h0000);
    check(16'({third_audio_receive, third_audio_frame_sync_in, third_audio_clock_in}),
          a3 ? 16'(data_pad_in[14:12]) : 16'h0000);
    check(lcd_data_bus_in, data_pad_in & l);
    check(16'(control_pad_out), sp ? 16'({spi_select, spi_clock}) : 16'(lcd_control_out));
    check(16'(spi_receive), 16'(sp ? data_pad_in[0] : (m == 3 || m == 5) ? data_pad_in[10] : 1'b0));
    check(16'(uart_receive), 16'((m == 1 || m == 4 || m == 5) ? data_pad_in[14] : 1'b1));
    if (m == PPM_MODE_2) check(16'(general_purpose_line_in[13:6]), 16'(data_pad_in[15:8]));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Read data are compared in the cycle after the strobe, oldest note first
  always @(posedge clock) rd_seen <= rd;
  always @(negedge clock) begin
    if (rd_seen) begin
      if (exp_q.size() > 0) check(rdata, exp_q.pop_front());
      else num_errors++;
    end else begin
      check(rdata, PPM_RDATA_IDLE);
    end
  end

  initial begin
    seed = 32'h096F75E3;
    regs = '{PPM_OFF_EXT_BUS_SEL, PPM_OFF_SLEW_SEL, PPM_OFF_PULL_INH_1, PPM_OFF_PULL_INH_2, PPM_OFF_PULL_INH_3};
    clock = 1'b0;
    rst = 1'b1;
    {wr, rd, addr, wdata} = '0;
    shake();
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd_reg(regs[i], 16'h0000);
    rd_reg(16'h1C1A, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr_reg(PPM_OFF_SLEW_SEL, v);
      wr_reg(PPM_OFF_PULL_INH_1, ~v);
      wr_reg(PPM_OFF_PULL_INH_2, v ^ 16'h5A5A);
      wr_reg(PPM_OFF_PULL_INH_3, v);
      wr_reg(16'h1C1A, v);
      rd_reg(PPM_OFF_SLEW_SEL, v);
      rd_reg(PPM_OFF_PULL_INH_1, ~v);
      rd_reg(PPM_OFF_PULL_INH_2, v ^ 16'h5A5A);
      rd_reg(PPM_OFF_PULL_INH_3, v & PPM_INH3_MASK);
      rd_reg(16'h1C1A, 16'h0000);
      @(negedge clock);
      check(pull_inhibit_first, ~v);
      check(pull_inhibit_second, v ^ 16'h5A5A);
      check(pull_inhibit_third, v & PPM_INH3_MASK);
      check(16'(test_reset_pull_down), 16'h0001);
      check(16'({external_memory_interface_slow, clock_output_pad_slow}), 16'(v[1:0]));
      check(16'(parallel_port_mode), 16'h0000);
    end
    for (int m = 0; m < 8; m++) begin
      v = (16'($random(seed)) & 16'h8FFF) | (16'(m) << PPM_MODE_LSB);
      wr_reg(PPM_OFF_EXT_BUS_SEL, v);
      rd_reg(PPM_OFF_EXT_BUS_SEL, 16'(m) << PPM_MODE_LSB);
      repeat (3) begin
        @(posedge clock);
        // Peripherals get fresh stimulus on each of the three checked cycles after a pad map change
        shake();
        @(negedge clock);
        check(16'(parallel_port_mode), 16'(m));
        pads(3'(m));
      end
    end
    wr_reg(PPM_OFF_PULL_INH_1, 16'hFFFF);
    wr_reg(PPM_OFF_SLEW_SEL, 16'hFFFF);
    @(negedge clock);
    check(16'(parallel_port_mode), 16'(PPM_MODE_7));
    @(posedge clock);
    rst <= 1'b1;
    @(negedge clock);
    check(16'(parallel_port_mode), 16'h0000);
    check(pull_inhibit_first, PPM_INH_RST);
    @(posedge clock);
    rst <= 1'b0;
    rd_reg(PPM_OFF_SLEW_SEL, PPM_SLEW_RST);
    // Write then read with no gap between the strobes
    v = 16'($random(seed));
    @(posedge clock);
    addr <= PPM_OFF_PULL_INH_1;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge clock);
    rd <= 1'b0;
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(negedge clock);
    if (exp_q.size() > 0) num_errors++;
    report_and_stop();
  end
endmodule
